//--- rtl/flash_seq_pkg.sv
/*
 holds the register map, field positions, reset values, command codes
 and timing counts of the flash self-programming sequencer.
 assumes an apb slave with 32-bit data and byte addresses equal to four
 times the printed offsets, which are kept as indices.
*/
package flash_seq_pkg;

   // ****************************************
   // register indices (byte address = index * 4)
   // ****************************************
   localparam logic [15:0] idx_protect_byte  = 16'h0081;
   localparam logic [15:0] idx_error_status  = 16'hffa1;
   localparam logic [15:0] idx_mode_ctrl     = 16'hffa2;
   localparam logic [15:0] idx_op_code       = 16'hffa3;
   localparam logic [15:0] idx_pointer_low   = 16'hffa4;
   localparam logic [15:0] idx_pointer_high  = 16'hffa5;
   localparam logic [15:0] idx_compare_low   = 16'hffa6;
   localparam logic [15:0] idx_compare_high  = 16'hffa7;
   localparam logic [15:0] idx_write_buffer  = 16'hffa8;
   localparam logic [15:0] idx_start         = 16'hffa9;
   localparam logic [15:0] idx_busy          = 16'hffaa;

   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int          op_code_width    = 3;
   localparam int          verify_err_bit   = 1;
   localparam int          protect_err_bit  = 2;
   localparam int          protect_lsb      = 2;
   localparam int          block_bits       = 2;
   localparam logic [7:0]  op_code_reset    = 8'h00;
   localparam logic [7:0]  compare_reset    = 8'h00;
   localparam logic [7:0]  write_buf_reset  = 8'h00;
   localparam logic [7:0]  erased_byte      = 8'hff;
   localparam logic [7:0]  protect_default  = 8'hff;

   // protect field codes of the smallest part
   localparam logic [4:0]  prot_blocks_3_0  = 5'h0e;
   localparam logic [4:0]  prot_blocks_1_0  = 5'h0f;
   localparam logic [4:0]  prot_none        = 5'h1f;

   // each write or erase command waits this many pclk cycles after its last cell write
   localparam int          cell_time_ns     = 100;
   localparam int          clk_period_ns    = 10;
   localparam int          cell_cycles      = (cell_time_ns + clk_period_ns - 1) / clk_period_ns;

   typedef enum logic [2:0] {
      cmd_none     = 3'h0,
      cmd_verify1  = 3'h1,
      cmd_verify2  = 3'h2,
      cmd_erase    = 3'h3,
      cmd_blank    = 3'h4,
      cmd_write    = 3'h5
   } op_code_t;

   // request from the sequencer to the flash array model
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } flash_req_t;

endpackage

//--- rtl/flash_array.sv
/*
 holds a 1 kbyte flash array: four blocks of 256 bytes, erased to ones.
 assumes one request per cycle from the sequencer; reads return the
 addressed byte on the next edge.
*/
`timescale 1ns/1ps
module flash_array
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire flash_seq_pkg::flash_req_t req,
   output logic [7:0]                     rdata
);

   logic [7:0] mem [0:1023];

   // no reset on the array: flash contents survive a system reset
   always_ff @(posedge pclk)
   begin
      if (req.wr)
      begin
         mem[req.addr[9:0]] <= req.wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata <= 8'h00;
      end
      else if (req.rd)
      begin
         rdata <= mem[req.addr[9:0]];
      end
   end

endmodule // flash_array

//--- rtl/flash_self_program_sequencer.sv
/*
 holds the flash self-programming sequencer with its apb register file.
 assumes an apb master on pclk; the cpu halt that starts a command is
 the halt_req input, and halt_release tells the cpu the command is done.
*/
// Behaviour
// R1 - command register resets to zero; only low three bits stored
// R2 - code 001 verifies a whole block; errors set status flags
// R3 - code 010 verifies several addresses in one block
// R4 - code 011 erases the block chosen by pointer high
// R5 - code 100 checks every byte of the block is erased
// R6 - code 101 programs write buffer byte at the pointer address
// R7 - byte write onto a zero bit that must become one flags error
// R8 - undefined codes abort at once and set an error flag
// R9 - pointer counts up until it equals the compare pair
// R10 - software reloads the pointer before every new command
// R11 - pointer has no reset value; compare registers reset to zero
// R12 - software keeps upper four bits of high bytes at zero
// R13 - verify: compare high equals pointer high, low is last address
// R14 - erase, verify, blank: compare high holds the block number
// R15 - compare low is zero for erase, all ones for blank check
// R16 - write buffer is eight bits and resets to zero
// R17 - protection applies only in self-program mode; protected data kept
// R18 - smallest part: 01110 guards blocks 3-0, 01111 blocks 1-0, 11111 none
// R19 - erase or write to protected block sets protect error
// R20 - verify failure sets verify error; write zero or reset clears it
// R21 - command starts when the cpu halts in self-program mode
// R22 - one command at a time; flags updated before cpu resumes
`timescale 1ns/1ps
module flash_self_program_sequencer
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  protect_byte_in,
   input  wire logic        halt_req,
   output logic             halt_release,
   output logic             busy
);

   // ****************************************
   // register file
   // ****************************************
   logic [2:0]  op_code;
   logic [7:0]  pointer_low;
   logic [7:0]  pointer_high;
   logic [7:0]  compare_low;
   logic [7:0]  compare_high;
   logic [7:0]  write_buffer;
   logic [7:0]  protect_byte;
   logic        self_prog_mode_select;
   logic        verify_error_flag;
   logic        write_protect_error_flag;
   logic        protect_loaded;

   typedef enum logic [2:0] {st_idle, st_read, st_check, st_prog, st_wait, st_done} seq_state_t;
   seq_state_t  state;
   logic [7:0]  cell_count;
   logic        start_cmd;
   logic        set_verify_err;
   logic        set_protect_err;
   logic        ptr_inc;
   logic        ptr_at_end;
   flash_seq_pkg::flash_req_t req;
   logic [7:0]  rdata;
   logic [7:0]  expect_byte;

   function automatic logic [15:0] reg_index(input logic [31:0] a);
      reg_index = a[17:2];
   endfunction

   // block guarded by the protect field of the smallest part
   function automatic logic block_guarded(input logic [4:0] field, input logic [1:0] blk);
      case (field)
         flash_seq_pkg::prot_blocks_3_0: block_guarded = 1'b1; // R18
         flash_seq_pkg::prot_blocks_1_0: block_guarded = (blk <= 2'h1); // R18
         flash_seq_pkg::prot_none:       block_guarded = 1'b0; // R18
         default:                        block_guarded = 1'b1;
      endcase
   endfunction

   logic        wr_acc;
   logic        rd_idx_ok;
   logic [15:0] idx;
   assign idx    = reg_index(paddr);
   assign wr_acc = psel && penable && pwrite;
   assign pready = 1'b1;

   always_comb
   begin
      rd_idx_ok = 1'b1;
      case (idx)
         flash_seq_pkg::idx_protect_byte, flash_seq_pkg::idx_error_status,
         flash_seq_pkg::idx_mode_ctrl, flash_seq_pkg::idx_op_code,
         flash_seq_pkg::idx_pointer_low, flash_seq_pkg::idx_pointer_high,
         flash_seq_pkg::idx_compare_low, flash_seq_pkg::idx_compare_high,
         flash_seq_pkg::idx_write_buffer, flash_seq_pkg::idx_start,
         flash_seq_pkg::idx_busy: rd_idx_ok = 1'b1;
         default: rd_idx_ok = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && (!rd_idx_ok || (paddr[1:0] != 2'h0));

   // protect byte caught after reset release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         protect_byte   <= flash_seq_pkg::protect_default;
         protect_loaded <= 1'b0;
      end
      else if (!protect_loaded)
      begin
         protect_byte   <= protect_byte_in;
         protect_loaded <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_code               <= flash_seq_pkg::op_code_reset[2:0]; // R1
         compare_low           <= flash_seq_pkg::compare_reset; // R11
         compare_high          <= flash_seq_pkg::compare_reset; // R11
         write_buffer          <= flash_seq_pkg::write_buf_reset; // R16
         self_prog_mode_select <= 1'b0;
      end
      else if (wr_acc && !busy && !pslverr)
      begin
         case (idx)
            flash_seq_pkg::idx_op_code:      op_code <= pwdata[2:0]; // R1
            flash_seq_pkg::idx_compare_low:  compare_low <= pwdata[7:0];
            flash_seq_pkg::idx_compare_high: compare_high <= pwdata[7:0];
            flash_seq_pkg::idx_write_buffer: write_buffer <= pwdata[7:0]; // R16
            flash_seq_pkg::idx_mode_ctrl:    self_prog_mode_select <= pwdata[0];
            default: ;
         endcase
      end
   end

   // pointer: no reset, counts toward the compare pair
   always_ff @(posedge pclk)
   begin
      if (wr_acc && !busy && idx == flash_seq_pkg::idx_pointer_low)
      begin
         pointer_low <= pwdata[7:0];
      end
      else if (ptr_inc)
      begin
         pointer_low <= pointer_low + 8'h01; // R9
      end
      if (wr_acc && !busy && idx == flash_seq_pkg::idx_pointer_high)
      begin
         pointer_high <= pwdata[7:0];
      end
      else if (ptr_inc && pointer_low == 8'hff)
      begin
         pointer_high <= pointer_high + 8'h01; // R9
      end
   end

   assign ptr_at_end = {pointer_high, pointer_low} == {compare_high, compare_low}; // R9

   // status flags: hardware set wins over software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         verify_error_flag        <= 1'b0; // R20
         write_protect_error_flag <= 1'b0;
      end
      else
      begin
         if (set_verify_err)
         begin
            verify_error_flag <= 1'b1; // R20
         end
         else if (wr_acc && idx == flash_seq_pkg::idx_error_status
                  && !pwdata[flash_seq_pkg::verify_err_bit])
         begin
            verify_error_flag <= 1'b0; // R20
         end
         if (set_protect_err)
         begin
            write_protect_error_flag <= 1'b1; // R19
         end
         else if (wr_acc && idx == flash_seq_pkg::idx_error_status
                  && !pwdata[flash_seq_pkg::protect_err_bit])
         begin
            write_protect_error_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (psel && !penable && !pwrite)
      begin
         case (idx)
            flash_seq_pkg::idx_protect_byte: prdata <= {24'h000000, protect_byte};
            flash_seq_pkg::idx_error_status: prdata <= {29'h0, write_protect_error_flag,
                                                        verify_error_flag, 1'b0};
            flash_seq_pkg::idx_mode_ctrl:    prdata <= {25'h0, protect_byte[6:2], 1'b0,
                                                        self_prog_mode_select};
            flash_seq_pkg::idx_op_code:      prdata <= {29'h0, op_code}; // R1
            flash_seq_pkg::idx_pointer_low:  prdata <= {24'h000000, pointer_low};
            flash_seq_pkg::idx_pointer_high: prdata <= {24'h000000, pointer_high};
            flash_seq_pkg::idx_compare_low:  prdata <= {24'h000000, compare_low};
            flash_seq_pkg::idx_compare_high: prdata <= {24'h000000, compare_high};
            flash_seq_pkg::idx_write_buffer: prdata <= {24'h000000, write_buffer};
            flash_seq_pkg::idx_busy:         prdata <= {31'h0, busy};
            default:                         prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   logic        guarded;
   // protection counts only in self-program mode
   assign guarded = self_prog_mode_select
                    && block_guarded(protect_byte[flash_seq_pkg::protect_lsb +: 5],
                                     pointer_high[flash_seq_pkg::block_bits-1:0]); // R17
   // software start register or cpu halt in self-program mode
   assign start_cmd = (state == st_idle)
                      && ((halt_req && self_prog_mode_select) // R21
                          || (wr_acc && idx == flash_seq_pkg::idx_start && pwdata[0]));
   assign busy = (state != st_idle); // R22

   // erase and blank check expect ones; verify compares with the write buffer
   assign expect_byte = (op_code == flash_seq_pkg::cmd_verify1 || op_code == flash_seq_pkg::cmd_verify2)
                        ? write_buffer : flash_seq_pkg::erased_byte;

   always_comb
   begin
      req       = '0;
      req.addr  = {pointer_high[3:0], pointer_low};
      req.wdata = write_buffer;
      ptr_inc   = 1'b0;
      set_verify_err  = 1'b0;
      set_protect_err = 1'b0;
      case (state)
         st_idle:
         begin
            if (start_cmd)
            begin
               case (op_code)
                  flash_seq_pkg::cmd_verify1, flash_seq_pkg::cmd_verify2, // R2 R3
                  flash_seq_pkg::cmd_blank: req.rd = 1'b1; // R5
                  flash_seq_pkg::cmd_erase, flash_seq_pkg::cmd_write:
                  begin
                     set_protect_err = guarded; // R19
                     req.rd = !guarded;
                  end
                  default: set_verify_err = 1'b1; // R8
               endcase
            end
         end
         st_check:
         begin
            case (op_code)
               flash_seq_pkg::cmd_write:
               begin
                  set_protect_err = |(write_buffer & ~rdata); // R7
               end
               flash_seq_pkg::cmd_erase: ;
               default:
               begin
                  set_verify_err = (rdata != expect_byte); // R2 R3 R5
                  ptr_inc = !ptr_at_end && (rdata == expect_byte); // R9
                  req.rd  = ptr_inc;
                  req.addr = {pointer_high[3:0], pointer_low + 8'h01};
               end
            endcase
         end
         st_prog:
         begin
            req.wr = 1'b1;
            if (op_code == flash_seq_pkg::cmd_erase)
            begin
               req.wdata = flash_seq_pkg::erased_byte; // R4
               // erase runs to the top of the block; compare low is zero here
               ptr_inc   = !(&pointer_low); // R9
            end
            else
            begin
               req.wdata = write_buffer & rdata; // R6
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state      <= st_idle;
         cell_count <= 8'h00;
      end
      else
      begin
         case (state)
            st_idle:
            begin
               if (req.rd)
               begin
                  state <= st_check;
               end
               else if (start_cmd)
               begin
                  state <= st_done; // R8
               end
            end
            st_check:
            begin
               if (op_code == flash_seq_pkg::cmd_erase)
               begin
                  state <= st_prog;
               end
               else if (op_code == flash_seq_pkg::cmd_write)
               begin
                  state <= set_protect_err ? st_done : st_prog; // R7
               end
               else if (!ptr_inc)
               begin
                  state <= st_done;
               end
            end
            st_prog:
            begin
               cell_count <= 8'(flash_seq_pkg::cell_cycles);
               state      <= (op_code == flash_seq_pkg::cmd_erase && !(&pointer_low))
                             ? st_prog : st_wait; // R4
            end
            st_wait:
            begin
               if (cell_count <= 8'h01)
               begin
                  state <= st_done;
               end
               else
               begin
                  cell_count <= cell_count - 8'h01;
               end
            end
            st_done:  state <= st_idle; // R22
            default:  state <= st_idle;
         endcase
      end
   end

   // cpu resumes only after the flags are settled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         halt_release <= 1'b0;
      end
      else
      begin
         halt_release <= (state == st_done); // R22
      end
   end

   flash_array u_array
   (
      .pclk    (pclk),
      .presetn (presetn),
      .req     (req),
      .rdata   (rdata)
   );

endmodule // flash_self_program_sequencer

//--- dv/flash_seq_sva.sv
/*
 concurrent checks on the ports of the flash self-programming sequencer.
 assumes aligned apb byte addresses; bound from tb_top.
*/
`timescale 1ns/1ps
module flash_seq_sva
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        halt_req,
   input wire logic        halt_release,
   input wire logic        busy
);
   // ****************************************
   // decoded access
   // ****************************************
   wire logic [15:0] idx     = paddr[17:2];
   wire logic        aligned = (paddr[31:18] == 14'h0) && (paddr[1:0] == 2'h0);
   wire logic        mapped  = (idx == flash_seq_pkg::idx_protect_byte) ||
                               (idx >= flash_seq_pkg::idx_error_status &&
                                idx <= flash_seq_pkg::idx_busy);
   wire logic        start_hit = psel && penable && pwrite && aligned && pwdata[0] &&
                                 (idx == flash_seq_pkg::idx_start) && !busy;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // read data is latched at the setup edge, so it is checked in the access cycle
   sequence op_read;
      psel && !penable && !pwrite && aligned && (idx == flash_seq_pkg::idx_op_code)
      ##1 psel && penable;
   endsequence

   ready_high_a: assert property (pready)
      else $error("pready low");
   unmapped_err_a: assert property (psel && penable && aligned && !mapped |-> pslverr)
      else $error("unmapped access without error");
   mapped_ok_a: assert property (psel && penable && aligned && mapped |-> !pslverr)
      else $error("mapped access flagged");
   start_busy_a: assert property (start_hit |=> busy)
      else $error("start did not raise busy");
   release_pulse_a: assert property (halt_release |=> !halt_release)
      else $error("halt release longer than one cycle");
   release_end_a: assert property (halt_release |-> !busy && $past(busy))
      else $error("halt release not at end of command");
   idle_quiet_a: assert property (!busy && !halt_req && !start_hit |=> !busy)
      else $error("command started without request");
   opcode_zero_a: assert property (op_read |-> prdata[31:3] == 29'h0)
      else $error("upper command bits not zero");
endmodule // flash_seq_sva

//--- dv/tb_top.sv
/*
 self-checking bench of the flash self-programming sequencer.
 assumes the package, the design and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
   logic        pclk     = 1'b0;
   logic        presetn  = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [31:0] paddr    = 32'h0;
   logic [31:0] pwdata   = 32'h0;
   logic [7:0]  prot     = 8'hff;
   logic        halt_req = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        halt_release;
   logic        busy;
   logic [7:0]  mem [1024];
   logic [31:0] rv;
   logic        last_err;
   logic [7:0]  d;
   logic        mode     = 1'b0;
   int          num_errors  = 0;
   int          checks_done = 0;

   always #5 pclk = ~pclk;

   flash_self_program_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .protect_byte_in(prot), .halt_req(halt_req),
      .halt_release(halt_release), .busy(busy));

   // ****************************************
   // bus tasks and model
   // ****************************************
   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask

   // one idle edge first so psel is never assigned twice in one step
   task automatic apb(input logic wr, input logic [15:0] i, input logic [7:0] wd);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {14'h0, i, 2'b00};
      pwdata <= {24'($urandom()), wd};
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for pready
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rv = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string w, input logic [15:0] i, input logic [31:0] e);
      apb(1'b0, i, 8'h00);
      chk(w, e, rv);
   endtask

   function automatic logic guarded(input logic [1:0] b);
      return mode && (prot[6:2] == flash_seq_pkg::prot_blocks_3_0 ||
                      (prot[6:2] == flash_seq_pkg::prot_blocks_1_0 && b <= 2'd1));
   endfunction

   task automatic cmd(input logic [2:0] code, input logic [7:0] hi, input logic [7:0] pl,
                      input logic [7:0] cl, input logic [7:0] wb, input logic via_halt,
                      input logic poke);
      int n;
      logic ev;
      logic ep;
      logic [9:0] adr;
      adr = {hi[1:0], pl};
      apb(1'b1, flash_seq_pkg::idx_error_status, 8'h00);
      apb(1'b1, flash_seq_pkg::idx_pointer_high, hi);
      apb(1'b1, flash_seq_pkg::idx_pointer_low, pl);
      apb(1'b1, flash_seq_pkg::idx_compare_high, hi);
      apb(1'b1, flash_seq_pkg::idx_compare_low, cl);
      apb(1'b1, flash_seq_pkg::idx_write_buffer, wb);
      apb(1'b1, flash_seq_pkg::idx_op_code, {5'h0, code});
      n = 0;
      if (via_halt)
      begin
         @(posedge pclk);
         halt_req <= 1'b1;
         do
         begin
            @(posedge pclk);
            n++;
         end
         while (busy !== 1'b1 && n < 20);
         chk("busy", 32'h1, {31'h0, busy});
         halt_req <= 1'b0;
      end
      else
         apb(1'b1, flash_seq_pkg::idx_start, 8'h01);
      if (poke)
         apb(1'b1, flash_seq_pkg::idx_write_buffer, ~wb);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (halt_release !== 1'b1 && n < 6000);
      chk("halt release", 32'h1, {31'h0, halt_release});
      ev = 1'b0;
      ep = 1'b0;
      case (code)
         3'h1, 3'h2: for (int a = pl; a <= cl; a++) ev |= (mem[{hi[1:0], 8'(a)}] !== wb);
         3'h3: if (guarded(hi[1:0])) ep = 1'b1;
               else for (int a = 0; a < 256; a++) mem[{hi[1:0], 8'(a)}] = 8'hff;
         3'h4: for (int a = pl; a <= cl; a++) ev |= (mem[{hi[1:0], 8'(a)}] !== 8'hff);
         3'h5: if (guarded(hi[1:0])) ep = 1'b1;
               else if ((wb & ~mem[adr]) != 8'h0)
               begin
                  ep = 1'b1;
                  mem[adr] = 8'hxx;
               end
               else mem[adr] = wb;
         default: ev = 1'b1;
      endcase
      apb(1'b0, flash_seq_pkg::idx_error_status, 8'h00);
      // a protect error leaves the verify flag clear; only bit 2 is judged then
      chk("status", {29'h0, ep, ev, 1'b0}, rv & (ep ? 32'h4 : 32'h6));
      if ((code == 3'h1 || code == 3'h4) && !ev)
         rchk("pointer low", flash_seq_pkg::idx_pointer_low, {24'h0, cl});
      if (poke)
         rchk("write buffer", flash_seq_pkg::idx_write_buffer, {24'h0, wb});
   endtask

   task automatic do_reset(input logic [4:0] field);
      presetn <= 1'b0;
      prot    <= {1'b1, field, 2'b11};
      mode = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task automatic set_mode(input logic m);
      apb(1'b1, flash_seq_pkg::idx_mode_ctrl, {7'h0, m});
      mode = m;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   initial
   begin
      void'($urandom(32'h2a6b));
      do_reset(flash_seq_pkg::prot_none);
      rchk("op code", flash_seq_pkg::idx_op_code, 32'h0);
      rchk("compare low", flash_seq_pkg::idx_compare_low, 32'h0);
      rchk("compare high", flash_seq_pkg::idx_compare_high, 32'h0);
      rchk("write buffer", flash_seq_pkg::idx_write_buffer, 32'h0);
      rchk("status", flash_seq_pkg::idx_error_status, 32'h0);
      rchk("mode", flash_seq_pkg::idx_mode_ctrl, 32'h7c);
      d = 8'($urandom());
      apb(1'b1, flash_seq_pkg::idx_op_code, d);
      rchk("op code", flash_seq_pkg::idx_op_code, {29'h0, d[2:0]});
      apb(1'b1, flash_seq_pkg::idx_protect_byte, 8'h00);
      rchk("protect byte", flash_seq_pkg::idx_protect_byte, 32'hff);
      apb(1'b0, 16'hffb0, 8'h00);
      chk("unmapped error", 32'h1, {31'h0, last_err});
      set_mode(1'b1);
      for (int b = 0; b < 4; b++)
      begin
         cmd(3'h3, 8'(b), 8'h00, 8'h00, 8'h00, b == 0, b == 2);
         cmd(3'h4, 8'(b), 8'h00, 8'hff, 8'h00, 1'b0, 1'b0);
      end
      d = 8'($urandom()) & 8'h7f;
      for (int i = 0; i < 3; i++)
         cmd(3'h5, 8'h01, 8'(8'h40 + i), 8'(8'h40 + i), d, 1'b0, 1'b0);
      cmd(3'h2, 8'h01, 8'h40, 8'h42, d, 1'b0, 1'b0);
      cmd(3'h2, 8'h01, 8'h40, 8'h42, d ^ 8'h01, 1'b0, 1'b0);
      cmd(3'h1, 8'h03, 8'h00, 8'hff, 8'hff, 1'b0, 1'b0);
      cmd(3'h5, 8'h03, 8'h80, 8'h80, 8'h00, 1'b0, 1'b0);
      cmd(3'h1, 8'h03, 8'h00, 8'hff, 8'hff, 1'b0, 1'b0);
      cmd(3'h4, 8'h03, 8'h00, 8'hff, 8'h00, 1'b0, 1'b0);
      cmd(3'h5, 8'h01, 8'h42, 8'h42, 8'h80, 1'b0, 1'b0);
      for (int c = 6; c < 8; c++)
         cmd(3'(c), 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
      set_mode(1'b0);
      @(posedge pclk);
      halt_req <= 1'b1;
      repeat (20) @(posedge pclk);
      chk("busy", 32'h0, {31'h0, busy});
      halt_req <= 1'b0;
      do_reset(flash_seq_pkg::prot_blocks_1_0);
      rchk("mode", flash_seq_pkg::idx_mode_ctrl, 32'h3c);
      set_mode(1'b1);
      cmd(3'h5, 8'h01, 8'h50, 8'h50, 8'h00, 1'b0, 1'b0);
      cmd(3'h3, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
      cmd(3'h2, 8'h01, 8'h40, 8'h41, d, 1'b0, 1'b0);
      cmd(3'h3, 8'h02, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
      set_mode(1'b0);
      cmd(3'h3, 8'h01, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
      cmd(3'h4, 8'h01, 8'h00, 8'hff, 8'h00, 1'b0, 1'b0);
      do_reset(flash_seq_pkg::prot_blocks_3_0);
      set_mode(1'b1);
      cmd(3'h3, 8'h03, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
      give_verdict();
   end

   // ends a hang well past the expected run length
   initial
   begin
      #900000;
      num_errors++;
      give_verdict();
   end
endmodule // tb_top

bind flash_self_program_sequencer flash_seq_sva chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
   .halt_release(halt_release), .busy(busy));
